//--- core/sbx_exec.sv
`timescale 1ns/1ps
`include "sbx_defs.svh"


module sbx_exec
    import sbx_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Instruction issue from fetch
    input wire logic instr_valid,
    input wire sbx_instr_t instr,
    output logic instr_ready,
    // Operand values, addressed by instr.reg_idx and instr.io_addr
    input wire logic [7:0] reg_rdata,
    input wire logic [7:0] io_rdata,
    // Results
    output sbx_reg_wr_t reg_wr,
    output sbx_io_wr_t io_wr,
    output logic [11:0] pc,
    output logic [7:0] status
);

    // ==========================================================
    // State
    sbx_core_t st;
    sbx_core_t next_st;

    logic [7:0] shift_res;
    logic shift_carry;
    logic do_shift;
    logic br_flag_idx_ok;
    logic [2:0] br_idx;
    logic br_pol;
    logic br_taken;
    logic is_branch;
    logic skip_hit;
    logic is_skip;
    logic [11:0] br_target;

    assign instr_ready = (st.state == SBX_IDLE);
    assign reg_wr = st.reg_wr;
    assign io_wr = st.io_wr;
    assign pc = st.pc;
    assign status = st.status;

    // ==========================================================
    // Branch condition: every branch except the signed pair reduces to one flag and a polarity
    always_comb begin
        br_idx = `SBX_FLAG_C;
        br_pol = 1'b1;
        is_branch = 1'b1;
        br_flag_idx_ok = 1'b1;
        case (instr.op)
            SBX_OP_BRANCH_ON_FLAG_ONE: begin
                br_idx = instr.bit_idx;
                br_pol = 1'b1;
            end
            SBX_OP_BRANCH_ON_FLAG_ZERO: begin
                br_idx = instr.bit_idx;
                br_pol = 1'b0;
            end
            SBX_OP_BRANCH_EQUAL: begin
                br_idx = `SBX_FLAG_Z;
                br_pol = 1'b1;
            end
            SBX_OP_BRANCH_NOT_EQUAL: begin
                br_idx = `SBX_FLAG_Z;
                br_pol = 1'b0;
            end
            SBX_OP_BRANCH_CARRY_ONE, SBX_OP_BRANCH_UNSIGNED_LT: begin
                br_idx = `SBX_FLAG_C;
                br_pol = 1'b1;
            end
            SBX_OP_BRANCH_CARRY_ZERO, SBX_OP_BRANCH_UNSIGNED_GE: begin
                br_idx = `SBX_FLAG_C;
                br_pol = 1'b0;
            end
            SBX_OP_BRANCH_NEGATIVE: begin
                br_idx = `SBX_FLAG_N;
                br_pol = 1'b1;
            end
            SBX_OP_BRANCH_NONNEGATIVE: begin
                br_idx = `SBX_FLAG_N;
                br_pol = 1'b0;
            end
            SBX_OP_BRANCH_OVERFLOW_ONE: begin
                br_idx = `SBX_FLAG_V;
                br_pol = 1'b1;
            end
            SBX_OP_BRANCH_OVERFLOW_ZERO: begin
                br_idx = `SBX_FLAG_V;
                br_pol = 1'b0;
            end
            SBX_OP_BRANCH_SIGNED_GE: begin
                br_flag_idx_ok = 1'b0;
                br_pol = 1'b0;
            end
            SBX_OP_BRANCH_SIGNED_LT: begin
                br_flag_idx_ok = 1'b0;
                br_pol = 1'b1;
            end
            SBX_OP_BRANCH_HALFCARRY_ONE: begin
                br_idx = `SBX_FLAG_H;
                br_pol = 1'b1;
            end
            SBX_OP_BRANCH_HALFCARRY_ZERO: begin
                br_idx = `SBX_FLAG_H;
                br_pol = 1'b0;
            end
            SBX_OP_BRANCH_TRANSFER_ONE: begin
                br_idx = `SBX_FLAG_T;
                br_pol = 1'b1;
            end
            SBX_OP_BRANCH_TRANSFER_ZERO: begin
                br_idx = `SBX_FLAG_T;
                br_pol = 1'b0;
            end
            SBX_OP_BRANCH_IRQ_ENABLED: begin
                br_idx = `SBX_FLAG_I;
                br_pol = 1'b1;
            end
            SBX_OP_BRANCH_IRQ_DISABLED: begin
                br_idx = `SBX_FLAG_I;
                br_pol = 1'b0;
            end
            default: begin
                is_branch = 1'b0;
            end
        endcase
        if (br_flag_idx_ok) begin
            br_taken = is_branch && (st.status[br_idx] == br_pol);
        end else begin
            // Signed compare result lives in N xor V
            br_taken = ((st.status[`SBX_FLAG_N] ^ st.status[`SBX_FLAG_V]) == br_pol);
        end
        br_target = st.pc + {{5{instr.offset[6]}}, instr.offset} + `SBX_PC_STEP;
    end

    // ==========================================================
    // Skip condition
    always_comb begin
        is_skip = 1'b1;
        case (instr.op)
            SBX_OP_SKIP_IF_REG_BIT_CLEAR: skip_hit = ~reg_rdata[instr.bit_idx];
            SBX_OP_SKIP_IF_REG_BIT_ONE: skip_hit = reg_rdata[instr.bit_idx];
            SBX_OP_SKIP_IF_IO_BIT_CLEAR: skip_hit = ~io_rdata[instr.bit_idx];
            SBX_OP_SKIP_IF_IO_BIT_ONE: skip_hit = io_rdata[instr.bit_idx];
            default: begin
                is_skip = 1'b0;
                skip_hit = 1'b0;
            end
        endcase
    end

    // ==========================================================
    // Shift and rotate unit
    always_comb begin
        do_shift = 1'b1;
        case (instr.op)
            SBX_OP_LOGICAL_LEFT_SHIFT: begin
                shift_res = {reg_rdata[6:0], 1'b0};
                shift_carry = reg_rdata[7];
            end
            SBX_OP_LOGICAL_RIGHT_SHIFT: begin
                shift_res = {1'b0, reg_rdata[7:1]};
                shift_carry = reg_rdata[0];
            end
            SBX_OP_ARITH_RIGHT_SHIFT: begin
                shift_res = {reg_rdata[7], reg_rdata[7:1]};
                shift_carry = reg_rdata[0];
            end
            SBX_OP_ROTATE_LEFT_CARRY: begin
                shift_res = {reg_rdata[6:0], st.status[`SBX_FLAG_C]};
                shift_carry = reg_rdata[7];
            end
            SBX_OP_ROTATE_RIGHT_CARRY: begin
                shift_res = {st.status[`SBX_FLAG_C], reg_rdata[7:1]};
                shift_carry = reg_rdata[0];
            end
            default: begin
                do_shift = 1'b0;
                shift_res = reg_rdata;
                shift_carry = 1'b0;
            end
        endcase
    end

    // ==========================================================
    // Next state
    always_comb begin
        next_st = st;
        next_st.reg_wr.we = 1'b0;
        next_st.io_wr.we = 1'b0;
        case (st.state)
            SBX_IDLE: begin
                if (instr_valid) begin
                    next_st.pc = st.pc + `SBX_PC_STEP;
                    next_st.long_skip = 1'b0;
                    if (is_skip && skip_hit) begin
                        // Extra cycles are the words being stepped over
                        next_st.pc = st.pc + (instr.next_two_word ? `SBX_SKIP_TWO_WORD
                                                                  : `SBX_SKIP_ONE_WORD);
                        next_st.long_skip = instr.next_two_word;
                        next_st.state = SBX_EXEC2;
                    end
                    if (br_taken) begin
                        next_st.pc = br_target;
                        next_st.state = SBX_EXEC2;
                    end
                    if (do_shift) begin
                        next_st.reg_wr = '{we: 1'b1, addr: instr.reg_idx, data: shift_res};
                        next_st.status[`SBX_FLAG_Z] = (shift_res == 8'h00);
                        next_st.status[`SBX_FLAG_C] = shift_carry;
                        next_st.status[`SBX_FLAG_N] = shift_res[7];
                        next_st.status[`SBX_FLAG_V] = shift_res[7] ^ shift_carry;
                    end
                    case (instr.op)
                        SBX_OP_IO_BIT_SET, SBX_OP_IO_BIT_CLEAR: begin
                            // Only the named bit is written, so write-one-to-clear
                            // flags elsewhere in the register are safe
                            next_st.io_wr = '{we: 1'b1, addr: instr.io_addr,
                                              bit_idx: instr.bit_idx,
                                              bit_val: (instr.op == SBX_OP_IO_BIT_SET)};
                            next_st.state = SBX_EXEC2;
                        end
                        SBX_OP_NIBBLE_SWAP: begin
                            next_st.reg_wr = '{we: 1'b1, addr: instr.reg_idx,
                                               data: {reg_rdata[3:0], reg_rdata[7:4]}};
                        end
                        SBX_OP_TRANSFER_TO_REG_BIT: begin
                            next_st.reg_wr.we = 1'b1;
                            next_st.reg_wr.addr = instr.reg_idx;
                            next_st.reg_wr.data = reg_rdata;
                            next_st.reg_wr.data[instr.bit_idx] = st.status[`SBX_FLAG_T];
                        end
                        SBX_OP_REG_BIT_TO_TRANSFER: begin
                            next_st.status[`SBX_FLAG_T] = reg_rdata[instr.bit_idx];
                        end
                        SBX_OP_STATUS_BIT_SET: next_st.status[instr.bit_idx] = 1'b1;
                        SBX_OP_STATUS_BIT_CLEAR: next_st.status[instr.bit_idx] = 1'b0;
                        SBX_OP_SET_CARRY_FLAG: next_st.status[`SBX_FLAG_C] = 1'b1;
                        SBX_OP_CLEAR_CARRY_FLAG: next_st.status[`SBX_FLAG_C] = 1'b0;
                        SBX_OP_SET_NEGATIVE_FLAG: next_st.status[`SBX_FLAG_N] = 1'b1;
                        SBX_OP_CLEAR_NEGATIVE_FLAG: next_st.status[`SBX_FLAG_N] = 1'b0;
                        SBX_OP_SET_ZERO_FLAG: next_st.status[`SBX_FLAG_Z] = 1'b1;
                        SBX_OP_CLEAR_ZERO_FLAG: next_st.status[`SBX_FLAG_Z] = 1'b0;
                        SBX_OP_GLOBAL_IRQ_ON: next_st.status[`SBX_FLAG_I] = 1'b1;
                        SBX_OP_GLOBAL_IRQ_OFF: next_st.status[`SBX_FLAG_I] = 1'b0;
                        SBX_OP_SET_SIGN_FLAG: next_st.status[`SBX_FLAG_S] = 1'b1;
                        SBX_OP_CLEAR_SIGN_FLAG: next_st.status[`SBX_FLAG_S] = 1'b0;
                        default: begin
                        end
                    endcase
                end
            end
            SBX_EXEC2: begin
                next_st.state = st.long_skip ? SBX_EXEC3 : SBX_IDLE;
            end
            SBX_EXEC3: begin
                next_st.state = SBX_IDLE;
                next_st.long_skip = 1'b0;
            end
            default: begin
                next_st.state = SBX_IDLE;
            end
        endcase
    end

    // ==========================================================
    // Registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st <= '{state: SBX_IDLE, long_skip: 1'b0, pc: `SBX_PC_RST,
                    status: `SBX_STATUS_RST, reg_wr: '0, io_wr: '0};
        end else begin
            st <= next_st;
        end
    end

endmodule : sbx_exec

//--- core/sbx_defs.svh
`ifndef SBX_DEFS_SVH
`define SBX_DEFS_SVH

// ==========================================================
// Widths
`define SBX_PC_W 12
`define SBX_REG_IDX_W 5
`define SBX_IO_ADDR_W 5

// ==========================================================
// Status register bit positions
`define SBX_FLAG_C 3'd0
`define SBX_FLAG_Z 3'd1
`define SBX_FLAG_N 3'd2
`define SBX_FLAG_V 3'd3
`define SBX_FLAG_S 3'd4
`define SBX_FLAG_H 3'd5
`define SBX_FLAG_T 3'd6
`define SBX_FLAG_I 3'd7

// ==========================================================
// Reset values and program counter steps
`define SBX_PC_RST 12'h000
`define SBX_STATUS_RST 8'h00
`define SBX_PC_STEP 12'h001
`define SBX_SKIP_ONE_WORD 12'h002
`define SBX_SKIP_TWO_WORD 12'h003

`endif

//--- core/sbx_pkg.sv
package sbx_pkg;

    // ==========================================================
    // Operations accepted from the fetch path
    typedef enum logic [5:0] {
        SBX_OP_NOP,
        SBX_OP_SKIP_IF_REG_BIT_CLEAR,
        SBX_OP_SKIP_IF_REG_BIT_ONE,
        SBX_OP_SKIP_IF_IO_BIT_CLEAR,
        SBX_OP_SKIP_IF_IO_BIT_ONE,
        SBX_OP_BRANCH_ON_FLAG_ONE,
        SBX_OP_BRANCH_ON_FLAG_ZERO,
        SBX_OP_BRANCH_EQUAL,
        SBX_OP_BRANCH_NOT_EQUAL,
        SBX_OP_BRANCH_CARRY_ONE,
        SBX_OP_BRANCH_CARRY_ZERO,
        SBX_OP_BRANCH_UNSIGNED_GE,
        SBX_OP_BRANCH_UNSIGNED_LT,
        SBX_OP_BRANCH_NEGATIVE,
        SBX_OP_BRANCH_NONNEGATIVE,
        SBX_OP_BRANCH_SIGNED_GE,
        SBX_OP_BRANCH_SIGNED_LT,
        SBX_OP_BRANCH_HALFCARRY_ONE,
        SBX_OP_BRANCH_HALFCARRY_ZERO,
        SBX_OP_BRANCH_TRANSFER_ONE,
        SBX_OP_BRANCH_TRANSFER_ZERO,
        SBX_OP_BRANCH_OVERFLOW_ONE,
        SBX_OP_BRANCH_OVERFLOW_ZERO,
        SBX_OP_BRANCH_IRQ_ENABLED,
        SBX_OP_BRANCH_IRQ_DISABLED,
        SBX_OP_IO_BIT_SET,
        SBX_OP_IO_BIT_CLEAR,
        SBX_OP_LOGICAL_LEFT_SHIFT,
        SBX_OP_LOGICAL_RIGHT_SHIFT,
        SBX_OP_ROTATE_LEFT_CARRY,
        SBX_OP_ROTATE_RIGHT_CARRY,
        SBX_OP_ARITH_RIGHT_SHIFT,
        SBX_OP_NIBBLE_SWAP,
        SBX_OP_STATUS_BIT_SET,
        SBX_OP_STATUS_BIT_CLEAR,
        SBX_OP_REG_BIT_TO_TRANSFER,
        SBX_OP_TRANSFER_TO_REG_BIT,
        SBX_OP_SET_CARRY_FLAG,
        SBX_OP_CLEAR_CARRY_FLAG,
        SBX_OP_SET_NEGATIVE_FLAG,
        SBX_OP_CLEAR_NEGATIVE_FLAG,
        SBX_OP_SET_ZERO_FLAG,
        SBX_OP_CLEAR_ZERO_FLAG,
        SBX_OP_GLOBAL_IRQ_ON,
        SBX_OP_GLOBAL_IRQ_OFF,
        SBX_OP_SET_SIGN_FLAG,
        SBX_OP_CLEAR_SIGN_FLAG
    } sbx_op_t;

    // Execution states, Gray coded along idle -> second -> third
    typedef enum logic [1:0] {
        SBX_IDLE = 2'b00,
        SBX_EXEC2 = 2'b01,
        SBX_EXEC3 = 2'b11
    } sbx_state_t;

    // One issued instruction
    typedef struct packed {
        sbx_op_t op;
        logic [2:0] bit_idx;
        logic [6:0] offset;
        logic [4:0] reg_idx;
        logic [4:0] io_addr;
        logic next_two_word;
    } sbx_instr_t;

    // Single-bit I/O write
    typedef struct packed {
        logic we;
        logic [4:0] addr;
        logic [2:0] bit_idx;
        logic bit_val;
    } sbx_io_wr_t;

    // General register write-back
    typedef struct packed {
        logic we;
        logic [4:0] addr;
        logic [7:0] data;
    } sbx_reg_wr_t;

    // Whole state of the executor
    typedef struct packed {
        sbx_state_t state;
        logic long_skip;
        logic [11:0] pc;
        logic [7:0] status;
        sbx_reg_wr_t reg_wr;
        sbx_io_wr_t io_wr;
    } sbx_core_t;

endpackage : sbx_pkg

//--- tb/sbx_exec_asserts.sv
`timescale 1ns/1ps
module sbx_exec_asserts
    import sbx_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Issue
    input wire logic instr_valid,
    input wire sbx_instr_t instr,
    input wire logic instr_ready,
    // Operands
    input wire logic [7:0] reg_rdata,
    input wire logic [7:0] io_rdata,
    // Results
    input wire sbx_reg_wr_t reg_wr,
    input wire sbx_io_wr_t io_wr,
    input wire logic [11:0] pc,
    input wire logic [7:0] status
);
    default clocking dcb @(posedge clk);
    endclocking
    default disable iff (rst);

    logic tk;
    logic [11:0] tgt;
    sbx_op_t op;
    assign tk = instr_valid && instr_ready;
    assign op = instr.op;
    // Taken-branch step: signed k plus one
    assign tgt = {{5{instr.offset[6]}}, instr.offset} + 12'h001;

    a_branch_taken:
    assert property (tk && op == SBX_OP_BRANCH_EQUAL && status[1] |=>
        (pc == $past(pc) + $past(tgt) && !instr_ready) ##1 instr_ready) else $error("bad taken");
    a_branch_fallthru:
    assert property (tk && op == SBX_OP_BRANCH_NOT_EQUAL && status[1] |=>
        pc == $past(pc) + 12'h001 && instr_ready) else $error("bad fall through");
    a_signed_branch:
    assert property (tk && op inside {SBX_OP_BRANCH_SIGNED_GE, SBX_OP_BRANCH_SIGNED_LT} |=>
        pc == $past(pc) + (($past(status[2] ^ status[3]) ^ $past(op == SBX_OP_BRANCH_SIGNED_LT))
        ? 12'h001 : $past(tgt))) else $error("bad signed branch");
    a_skip_long:
    assert property (tk && op == SBX_OP_SKIP_IF_REG_BIT_ONE && reg_rdata[instr.bit_idx] &&
        instr.next_two_word |=> (pc == $past(pc) + 12'h003 && !instr_ready) ##1 !instr_ready
        ##1 instr_ready) else $error("bad long skip");
    a_skip_io_short:
    assert property (tk && op == SBX_OP_SKIP_IF_IO_BIT_CLEAR && !io_rdata[instr.bit_idx] &&
        !instr.next_two_word |=> (pc == $past(pc) + 12'h002 && !instr_ready) ##1 instr_ready)
        else $error("bad short skip");
    a_io_bit_write:
    assert property (tk && op inside {SBX_OP_IO_BIT_SET, SBX_OP_IO_BIT_CLEAR} |=>
        (io_wr.we && io_wr.addr == $past(instr.io_addr) && io_wr.bit_idx == $past(instr.bit_idx)
        && io_wr.bit_val == $past(op == SBX_OP_IO_BIT_SET) && !instr_ready)
        ##1 (instr_ready && !io_wr.we)) else $error("bad io bit write");
    a_flags_kept:
    assert property (tk && op inside {[SBX_OP_SKIP_IF_REG_BIT_CLEAR:SBX_OP_IO_BIT_CLEAR]} |=>
        status == $past(status)) else $error("flags changed");
    a_swap_data:
    assert property (tk && op == SBX_OP_NIBBLE_SWAP |=> reg_wr.we && status == $past(status)
        && reg_wr.data == {$past(reg_rdata[3:0]), $past(reg_rdata[7:4])}) else $error("bad swap");
    a_shift_left_flags:
    assert property (tk && op == SBX_OP_LOGICAL_LEFT_SHIFT |=>
        reg_wr.data == {$past(reg_rdata[6:0]), 1'b0} && status[0] == $past(reg_rdata[7]) &&
        status[1] == (reg_wr.data == 8'h00) && status[2] == reg_wr.data[7] &&
        status[3] == (reg_wr.data[7] ^ status[0])) else $error("bad left shift");
    a_transfer_store:
    assert property (tk && op == SBX_OP_REG_BIT_TO_TRANSFER |=> !reg_wr.we && status ==
        {$past(status[7]), $past(reg_rdata[instr.bit_idx]), $past(status[5:0])})
        else $error("bad bit store");
endmodule : sbx_exec_asserts

bind sbx_exec sbx_exec_asserts sbx_exec_asserts_inst (.clk(clk), .rst(rst),
    .instr_valid(instr_valid), .instr(instr), .instr_ready(instr_ready),
    .reg_rdata(reg_rdata), .io_rdata(io_rdata), .reg_wr(reg_wr), .io_wr(io_wr),
    .pc(pc), .status(status));

//--- tb/sbx_fetch.sv
`timescale 1ns/1ps
module sbx_fetch
    import sbx_pkg::*;
(
    // Clock
    input wire logic clk,
    // Issue
    output logic instr_valid,
    output sbx_instr_t instr,
    input wire logic instr_ready,
    // Operands and write-back
    output logic [7:0] reg_rdata,
    output logic [7:0] io_rdata,
    input wire sbx_reg_wr_t reg_wr,
    input wire sbx_io_wr_t io_wr
);
    logic [7:0] regs [32];
    logic [7:0] io [32];

    initial begin
        instr_valid = 1'b0;
        instr = '0;
        for (int n = 0; n < 32; n++) begin
            regs[n] = 8'h00;
            io[n] = 8'h00;
        end
    end

    assign reg_rdata = regs[instr.reg_idx];
    assign io_rdata = io[instr.io_addr];

    always @(posedge clk) begin
        if (reg_wr.we) begin
            regs[reg_wr.addr] <= reg_wr.data;
        end
        if (io_wr.we) begin
            io[io_wr.addr][io_wr.bit_idx] <= io_wr.bit_val;
        end
    end

    // ==========================================================
    // Issue one word, held until an edge sees ready high or 16 edges pass
    task automatic issue(input sbx_instr_t i, input int gap, output logic ok);
        logic r;
        ok = 1'b0;
        repeat (gap) @(posedge clk);
        instr_valid <= 1'b1;
        instr <= i;
        for (int n = 0; n < 16 && !ok; n++) begin
            @(negedge clk);
            r = instr_ready;
            @(posedge clk);
            ok = r;
        end
        instr_valid <= 1'b0;
        // Idle bus shows junk, never the last word
        instr <= sbx_instr_t'(~i);
    endtask : issue
endmodule : sbx_fetch

//--- tb/sbx_exec_tb.sv
`timescale 1ns/1ps
module sbx_exec_tb
    import sbx_pkg::*;
();
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic instr_valid, instr_ready, hit, io_op, t, we;
    sbx_instr_t instr;
    logic [7:0] reg_rdata, io_rdata, status, esr, ssr, m, v, ns, r;
    sbx_reg_wr_t reg_wr, srw;
    sbx_io_wr_t io_wr, siw;
    logic [11:0] pc, epc, spc;
    logic [2:0] b;
    int errors = 0;
    int num_checks = 0;
    int busy;
    logic [7:0] pat [8] = '{8'h00, 8'hff, 8'h0c, 8'h08, 8'h04, 8'ha3, 8'h5c, 8'h61};
    logic [6:0] off [8] = '{7'h05, 7'h7c, 7'h3f, 7'h40, 7'h01, 7'h7f, 7'h10, 7'h00};
    logic [7:0] dv [4] = '{8'h81, 8'h00, 8'h40, 8'hfe};
    sbx_op_t fo [10] = '{SBX_OP_SET_CARRY_FLAG, SBX_OP_CLEAR_CARRY_FLAG, SBX_OP_SET_NEGATIVE_FLAG,
        SBX_OP_CLEAR_NEGATIVE_FLAG, SBX_OP_SET_ZERO_FLAG, SBX_OP_CLEAR_ZERO_FLAG,
        SBX_OP_GLOBAL_IRQ_ON, SBX_OP_GLOBAL_IRQ_OFF, SBX_OP_SET_SIGN_FLAG, SBX_OP_CLEAR_SIGN_FLAG};
    int fb [10] = '{0, 0, 2, 2, 1, 1, 7, 7, 4, 4};

    always #10 clk = ~clk;

    sbx_exec sbx_exec_inst (.clk(clk), .rst(rst), .instr_valid(instr_valid), .instr(instr),
        .instr_ready(instr_ready), .reg_rdata(reg_rdata), .io_rdata(io_rdata),
        .reg_wr(reg_wr), .io_wr(io_wr), .pc(pc), .status(status));
    sbx_fetch sbx_fetch_inst (.clk(clk), .instr_valid(instr_valid), .instr(instr),
        .instr_ready(instr_ready), .reg_rdata(reg_rdata), .io_rdata(io_rdata),
        .reg_wr(reg_wr), .io_wr(io_wr));

    // ==========================================================
    // Reporting
    task automatic give_verdict;
        if (errors == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : give_verdict

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // ==========================================================
    // Issue, snapshot the cycle after, then count busy cycles
    task automatic run(input sbx_instr_t i, input int gap);
        logic ok;
        sbx_fetch_inst.issue(i, gap, ok);
        #1;
        spc = pc;
        ssr = status;
        srw = reg_wr;
        siw = io_wr;
        busy = 0;
        while (ok && instr_ready !== 1'b1 && busy < 8) begin
            @(posedge clk);
            #1;
            busy++;
        end
        if (!ok || busy == 8) begin
            errors++;
            give_verdict();
        end
    endtask : run

    function automatic sbx_instr_t mk(sbx_op_t o, logic [2:0] bi, logic [6:0] k, logic w);
        return '{op: o, bit_idx: bi, offset: k, reg_idx: 5'd5, io_addr: 5'd9, next_two_word: w};
    endfunction : mk

    task automatic set_status(input logic [7:0] x);
        for (int n = 0; n < 8; n++) begin
            run(mk(x[n] ? SBX_OP_STATUS_BIT_SET : SBX_OP_STATUS_BIT_CLEAR, 3'(n), 7'h00, 1'b0), 0);
            epc = epc + 12'h001;
        end
        esr = x;
        check(16'(ssr), 16'(x));
        check(16'(spc), 16'(epc));
    endtask : set_status

    function automatic logic tk(sbx_op_t o, logic [7:0] s, logic [2:0] bi);
        case (o)
            SBX_OP_BRANCH_ON_FLAG_ONE: return s[bi];
            SBX_OP_BRANCH_ON_FLAG_ZERO: return !s[bi];
            SBX_OP_BRANCH_EQUAL, SBX_OP_BRANCH_CARRY_ONE: return s[o == SBX_OP_BRANCH_EQUAL];
            SBX_OP_BRANCH_NOT_EQUAL: return !s[1];
            SBX_OP_BRANCH_CARRY_ZERO, SBX_OP_BRANCH_UNSIGNED_GE: return !s[0];
            SBX_OP_BRANCH_UNSIGNED_LT: return s[0];
            SBX_OP_BRANCH_NEGATIVE: return s[2];
            SBX_OP_BRANCH_NONNEGATIVE: return !s[2];
            SBX_OP_BRANCH_SIGNED_GE: return !(s[2] ^ s[3]);
            SBX_OP_BRANCH_SIGNED_LT: return s[2] ^ s[3];
            // Half-carry sits at bit 5 and transfer at bit 6
            SBX_OP_BRANCH_HALFCARRY_ONE, SBX_OP_BRANCH_TRANSFER_ONE: return s[(o + 1) / 2 - 4];
            SBX_OP_BRANCH_HALFCARRY_ZERO, SBX_OP_BRANCH_TRANSFER_ZERO: return !s[o / 2 - 4];
            SBX_OP_BRANCH_OVERFLOW_ONE: return s[3];
            SBX_OP_BRANCH_OVERFLOW_ZERO: return !s[3];
            SBX_OP_BRANCH_IRQ_ENABLED: return s[7];
            default: return !s[7];
        endcase
    endfunction : tk

    function automatic logic [15:0] alu(sbx_op_t o, logic [7:0] d, logic [7:0] s, logic [2:0] bi);
        logic [7:0] q;
        logic [7:0] f;
        logic c;
        q = d;
        f = s;
        c = s[0];
        case (o)
            SBX_OP_LOGICAL_LEFT_SHIFT: {c, q} = {d, 1'b0};
            SBX_OP_LOGICAL_RIGHT_SHIFT: {q, c} = {1'b0, d};
            SBX_OP_ROTATE_LEFT_CARRY: {c, q} = {d, s[0]};
            SBX_OP_ROTATE_RIGHT_CARRY: {q, c} = {s[0], d};
            SBX_OP_ARITH_RIGHT_SHIFT: {q, c} = {d[7], d};
            SBX_OP_NIBBLE_SWAP: q = {d[3:0], d[7:4]};
            SBX_OP_STATUS_BIT_SET: f[bi] = 1'b1;
            SBX_OP_STATUS_BIT_CLEAR: f[bi] = 1'b0;
            SBX_OP_REG_BIT_TO_TRANSFER: f[6] = d[bi];
            default: q[bi] = s[6];
        endcase
        if (o <= SBX_OP_ARITH_RIGHT_SHIFT) begin
            f[3:0] = {q[7] ^ c, q[7], q == 8'h00, c};
        end
        return {f, q};
    endfunction : alu

    // ==========================================================
    // Scenarios
    initial begin
        epc = 12'h000;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        #1;
        check(16'({pc, status[3:0]}), 16'h0000);
        check(16'({instr_ready, status[7:4]}), 16'h0010);
        // Dedicated flag forms touch one bit each
        set_status(8'h68);
        for (int n = 0; n < 10; n++) begin
            run(mk(fo[n], 3'h0, 7'h00, 1'b0), 0);
            epc = epc + 12'h001;
            esr[fb[n]] = !n[0];
            check(16'({busy[3:0], ssr}), 16'(esr));
        end
        // Every branch against every flag pattern
        foreach (pat[p]) begin
            set_status(pat[p]);
            for (int k = SBX_OP_BRANCH_ON_FLAG_ONE; k <= SBX_OP_BRANCH_IRQ_DISABLED; k++) begin
                t = tk(sbx_op_t'(k), pat[p], 3'(p));
                run(mk(sbx_op_t'(k), 3'(p), off[p], 1'b0), p % 2);
                epc = epc + (t ? {{5{off[p][6]}}, off[p]} + 12'h001 : 12'h001);
                check(16'(spc), 16'(epc));
                check(16'({busy[3:0], ssr}), 16'({3'h0, t, esr}));
            end
        end
        // Skips, one and two word, prompt and slow issue
        for (int k = SBX_OP_SKIP_IF_REG_BIT_CLEAR; k <= SBX_OP_SKIP_IF_IO_BIT_ONE; k++) begin
            for (int c = 0; c < 8; c++) begin
                b = 3'(c * 3 + k);
                m = 8'h01 << b;
                v = c[0] ? m : ~m;
                hit = (k == SBX_OP_SKIP_IF_REG_BIT_ONE || k == SBX_OP_SKIP_IF_IO_BIT_ONE) == c[0];
                io_op = k >= SBX_OP_SKIP_IF_IO_BIT_CLEAR;
                sbx_fetch_inst.regs[5] = io_op ? ~v : v;
                sbx_fetch_inst.io[9] = io_op ? v : ~v;
                run(mk(sbx_op_t'(k), b, 7'h00, c[1]), c / 4);
                epc = epc + (hit ? (c[1] ? 12'h003 : 12'h002) : 12'h001);
                check(16'(spc), 16'(epc));
                check(16'({busy[3:0], ssr}), 16'({2'h0, hit & c[1], hit & !c[1], esr}));
            end
        end
        // Shifts, swap, bit transfer and generic flag forms
        for (int j = 0; j < 4; j++) begin
            set_status(pat[j + 1]);
            for (int k = SBX_OP_LOGICAL_LEFT_SHIFT; k <= SBX_OP_TRANSFER_TO_REG_BIT; k++) begin
                b = 3'(k + j);
                sbx_fetch_inst.regs[5] = dv[j];
                {ns, r} = alu(sbx_op_t'(k), dv[j], esr, b);
                we = !(k inside {[SBX_OP_STATUS_BIT_SET:SBX_OP_REG_BIT_TO_TRANSFER]});
                run(mk(sbx_op_t'(k), b, 7'h00, 1'b0), 0);
                epc = epc + 12'h001;
                esr = ns;
                check(16'({busy[3:0], ssr}), 16'(ns));
                check(16'({srw.we, spc}), 16'({we, epc}));
                if (we) begin
                    check(16'({srw.addr, srw.data}), 16'({5'd5, r}));
                end
            end
        end
        // I/O bit set and clear over all bit positions
        for (int c = 0; c < 16; c++) begin
            b = 3'(c);
            run(mk(c[3] ? SBX_OP_IO_BIT_CLEAR : SBX_OP_IO_BIT_SET, b, 7'h00, 1'b0), 0);
            epc = epc + 12'h001;
            check(16'(siw), 16'({1'b1, 5'd9, b, !c[3]}));
            check(16'({busy[3:0], ssr}), 16'({4'h1, esr}));
            check(16'(spc), 16'(epc));
        end
        give_verdict();
    end
endmodule : sbx_exec_tb
